// ---- src/vcc_fifo.sv ----
// vcc_fifo: word fifo with registered read data
// assumes one clock; depth counts the output register too
`timescale 1ns/100ps
module vcc_fifo
  import vcc_pkg::*;
#(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] cnt;
  logic [CW-1:0] mem_cnt;
  logic push;
  logic pop;
  logic load;

  // handshake terms
  assign in_ready = (cnt < CW'(DEPTH));
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign mem_cnt = cnt - CW'(out_valid);
  assign load = (!out_valid || out_ready) && (mem_cnt != '0);

  // storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers and occupancy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      cnt <= '0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (load) rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      cnt <= cnt + CW'(push) - CW'(pop);
    end
  end

  // registered head word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (load) begin
      out_valid <= 1'b1;
      out_data <= mem[rd_ptr];
    end else if (pop) begin
      out_valid <= 1'b0;
    end
  end
endmodule

// ---- src/vcc_pkg.sv ----
// video capture control: shared constants and encodings
// assumes one 20 MHz clock and 32-bit apb, one word per register
//
// Functional notes
// - field select 00 means progressive input; no interlaced source may be fed.
// - field select 01 captures both fields into one frame, no interpolation.
// - field select 10 captures only fields with field parity low.
// - field select 11 captures only fields with field parity high.
// - field select 00 starts a storage area every vertical sync period.
// - field select 01 starts a storage area every two periods, both fields.
// - upper select bit set: area every two periods, one field stored.
// - vertical size counts kept lines over two periods for 01, else one.
// - conversion bit 0 stores captured 4:2:2 words unchanged.
// - conversion bit 1 stores pixels converted to rgb.
// - capture enable 0 stops capture, 1 captures.
// - control bits 3..0 are read/write and reset to zero.
// - reduction bits 9..8 select vertical ratio 1, 1/2, 1/3, 1/4.
package vcc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STAT_OFS = 12'h004;
  localparam logic [11:0] ACT_OFS = 12'h008;

  // control field positions
  localparam int CTL_EN_BIT = 0;
  localparam int CTL_RGB_BIT = 1;
  localparam int CTL_FS_LO = 2;
  localparam int CTL_FS_HI = 3;
  localparam int CTL_RED_LO = 5;
  localparam int CTL_RED_HI = 9;
  localparam logic [9:0] CTRL_RST = 10'h000;
  localparam logic [9:0] CTRL_MASK = 10'h3ef;

  // status field positions
  localparam int ST_VSIZE_LO = 0;
  localparam int ST_AREA_LO = 12;
  localparam int ST_BAD_BIT = 14;
  localparam int ST_OVF_BIT = 15;
  localparam int ST_CAP_BIT = 16;

  // ----------------------------------------------------------------
  // field select encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] FS_PROG = 2'h0;
  localparam logic [1:0] FS_MERGE = 2'h1;
  localparam logic [1:0] FS_ODD = 2'h2;
  localparam logic [1:0] FS_EVEN = 2'h3;
  localparam logic [1:0] AREA_LAST = 2'h2;

  // ----------------------------------------------------------------
  // stream sizes and colour conversion coefficients (x256)
  // ----------------------------------------------------------------
  localparam int LINE_W = 12;
  localparam int PIX_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam logic signed [10:0] K_RV = 11'sh167;
  localparam logic signed [10:0] K_GU = 11'sh058;
  localparam logic signed [10:0] K_GV = 11'sh0b7;
  localparam logic signed [10:0] K_BU = 11'sh1c6;
  localparam logic [7:0] C_MID = 8'h80;

endpackage

// ---- src/vcc_rgb.sv ----
// vcc_rgb: one-stage yuv to rgb565 converter
// assumes y, u, v are presented in the cycle of the pixel
`timescale 1ns/100ps
module vcc_rgb
  import vcc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pixel in
  input wire logic [7:0] y,
  input wire logic [7:0] u,
  input wire logic [7:0] v,
  // pixel out
  output logic [15:0] rgb
);
  logic signed [8:0] du;
  logic signed [8:0] dv;
  logic signed [20:0] r_s;
  logic signed [20:0] g_s;
  logic signed [20:0] b_s;
  logic signed [20:0] y_s;
  logic [7:0] r8;
  logic [7:0] g8;
  logic [7:0] b8;

  // clamp to an 8-bit channel
  function automatic logic [7:0] clip(input logic signed [20:0] s);
    if (s < 0) return 8'h00;
    else if (s > 21'sd255) return 8'hff;
    else return s[7:0];
  endfunction

  // centred chroma and channel sums
  always_comb begin
    du = $signed({1'b0, u}) - $signed({1'b0, C_MID});
    dv = $signed({1'b0, v}) - $signed({1'b0, C_MID});
    y_s = $signed({13'h0000, y});
    r_s = y_s + ((K_RV * dv) >>> 8);
    g_s = y_s - ((K_GU * du + K_GV * dv) >>> 8);
    b_s = y_s + ((K_BU * du) >>> 8);
    r8 = clip(r_s);
    g8 = clip(g_s);
    b8 = clip(b_s);
  end

  // registered rgb565 word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rgb <= '0;
    end else begin
      rgb <= {r8[7:3], g8[7:2], b8[7:3]};
    end
  end
endmodule

// ---- src/vcc_top.sv ----
// vcc_top: video capture control with apb registers and store stream
// assumes synchronous video inputs and a memory writer on the store side
`timescale 1ns/100ps
module vcc_top
  import vcc_pkg::*;
#(
  parameter int FDEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // video source
  input wire logic video_vsync_in,
  input wire logic field_parity_in,
  input wire logic line_valid_in,
  input wire logic pix_valid,
  input wire logic [PIX_W-1:0] pix_data,
  // store stream toward graphics memory
  output logic st_valid,
  input wire logic st_ready,
  output logic [PIX_W-1:0] st_data,
  output logic st_field,
  output logic st_first,
  output logic area_start,
  output logic [1:0] area_idx
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [9:0] ctrl;
  logic [1:0] c_fsel;
  logic c_en;
  logic [1:0] act_fsel;
  logic act_rgb;
  logic act_en;
  logic [4:0] act_red;
  logic fld_par;
  logic cap_on;
  logic phase;
  logic vs_d;
  logic vs_rise;
  logic next_keep;
  logic next_start;
  logic next_phase;
  logic area_open;
  logic pend_first;
  logic [LINE_W-1:0] line_cnt;
  logic [LINE_W-1:0] storage_vertical_size;
  logic line_d;
  logic line_rise;
  logic line_first;
  logic line_keep;
  logic keep_now;
  logic [1:0] vcnt;
  logic [1:0] next_vcnt;
  logic [2:0] hcnt;
  logic [2:0] hmax;
  logic red_bad;
  logic cph;
  logic [7:0] u_hold;
  logic [7:0] v_hold;
  logic take;
  logic stg_valid;
  logic [PIX_W-1:0] stg_raw;
  logic stg_field;
  logic stg_first;
  logic [PIX_W-1:0] rgb_q;
  logic [PIX_W-1:0] stg_word;
  logic fifo_in_ready;
  logic ovf;
  logic apb_wr;
  logic apb_setup;
  logic addr_hit;

  assign c_fsel = ctrl[CTL_FS_HI:CTL_FS_LO];
  assign c_en = ctrl[CTL_EN_BIT];

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  assign pready = 1'b1;
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite;
  assign addr_hit = (paddr == CTRL_OFS) || (paddr == STAT_OFS) || (paddr == ACT_OFS);

  // control register, field order and reserved bits read zero
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= CTRL_RST;
    end else if (apb_wr && paddr == CTRL_OFS) begin
      ctrl <= pwdata[9:0] & CTRL_MASK;
    end
  end

  // read data and error latched in the setup cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      pslverr <= !addr_hit;
      prdata <= '0;
      if (!pwrite) begin
        case (paddr)
          CTRL_OFS: prdata <= {22'h00_0000, ctrl};
          STAT_OFS: begin
            prdata[ST_VSIZE_LO +: LINE_W] <= storage_vertical_size;
            prdata[ST_AREA_LO +: 2] <= area_idx;
            prdata[ST_BAD_BIT] <= red_bad;
            prdata[ST_OVF_BIT] <= ovf;
            prdata[ST_CAP_BIT] <= cap_on;
          end
          ACT_OFS: begin
            prdata[CTL_RED_HI:CTL_RED_LO] <= act_red;
            prdata[CTL_FS_HI:CTL_FS_LO] <= act_fsel;
            prdata[CTL_RGB_BIT] <= act_rgb;
            prdata[CTL_EN_BIT] <= act_en;
          end
          default: prdata <= '0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // vertical sync boundary and field decode
  // ----------------------------------------------------------------
  assign vs_rise = video_vsync_in && !vs_d;

  // decide capture and area start for the coming period
  always_comb begin
    case (c_fsel)
      FS_PROG: next_keep = c_en; // every period is a frame
      FS_MERGE: next_keep = c_en; // both fields kept
      FS_ODD: next_keep = c_en && !field_parity_in;
      FS_EVEN: next_keep = c_en && field_parity_in;
      default: next_keep = 1'b0;
    endcase
    next_phase = (c_fsel == FS_MERGE) && next_keep && !phase;
    next_start = next_keep && ((c_fsel != FS_MERGE) || !phase);
  end

  // shadow settings loaded only at the sync edge
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      vs_d <= 1'b0;
      act_fsel <= FS_PROG;
      act_rgb <= 1'b0;
      act_en <= 1'b0;
      act_red <= '0;
      fld_par <= 1'b0;
      cap_on <= 1'b0;
      phase <= 1'b0;
    end else begin
      vs_d <= video_vsync_in;
      if (vs_rise) begin
        act_fsel <= c_fsel;
        act_rgb <= ctrl[CTL_RGB_BIT];
        act_red <= ctrl[CTL_RED_HI:CTL_RED_LO];
        act_en <= c_en;
        fld_par <= field_parity_in;
        cap_on <= next_keep;
        phase <= next_phase;
      end
    end
  end

  // storage areas: start pulse, rotation and vertical size
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      area_start <= 1'b0;
      area_open <= 1'b0;
      area_idx <= '0;
      pend_first <= 1'b0;
      storage_vertical_size <= '0;
      line_cnt <= '0;
    end else begin
      area_start <= vs_rise && next_start;
      if (vs_rise && (next_start || !c_en)) begin
        if (area_open) storage_vertical_size <= line_cnt;
        area_open <= next_start;
        line_cnt <= '0;
      end else if (cap_on && line_rise && keep_now) begin
        line_cnt <= line_cnt + 1'b1; // kept lines only
      end
      if (vs_rise && next_start) begin
        area_idx <= (area_idx == AREA_LAST) ? '0 : area_idx + 1'b1;
        pend_first <= 1'b1;
      end else if (take) begin
        pend_first <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // reduction ratio decode
  // ----------------------------------------------------------------
  // prohibited codes fall back to full horizontal width and are flagged
  always_comb begin
    case (act_red)
      5'h00, 5'h01, 5'h02, 5'h09, 5'h0a, 5'h0b,
      5'h0c, 5'h12, 5'h13, 5'h1b, 5'h1c: red_bad = 1'b0;
      default: red_bad = 1'b1;
    endcase
    case (act_red[2:0])
      3'h0: hmax = 3'h0; // 1
      3'h1: hmax = 3'h1; // 1/2
      3'h2: hmax = 3'h2; // 1/3
      3'h3: hmax = 3'h5; // 1/6
      3'h4: hmax = 3'h3; // 1/4
      default: hmax = 3'h0;
    endcase
    if (red_bad) hmax = 3'h0;
  end

  // ----------------------------------------------------------------
  // line and pixel thinning
  // ----------------------------------------------------------------
  assign line_rise = line_valid_in && !line_d;
  // vertical ratio minus one is the upper reduction pair itself
  assign next_vcnt = (line_first || vcnt == act_red[4:3]) ? 2'h0 : vcnt + 1'b1;
  assign keep_now = line_rise ? (next_vcnt == 2'h0) : line_keep;
  assign take = cap_on && line_valid_in && pix_valid && keep_now && (hcnt == 3'h0);

  // line phase tracking
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      line_d <= 1'b0;
      line_first <= 1'b1;
      line_keep <= 1'b0;
      vcnt <= '0;
    end else begin
      line_d <= line_valid_in;
      if (vs_rise) begin
        line_first <= 1'b1;
      end else if (line_rise) begin
        line_first <= 1'b0;
        vcnt <= next_vcnt;
        line_keep <= (next_vcnt == 2'h0);
      end
    end
  end

  // pixel phase and chroma hold
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      hcnt <= '0;
      cph <= 1'b0;
      u_hold <= C_MID;
      v_hold <= C_MID;
    end else if (!line_valid_in) begin
      hcnt <= '0;
      cph <= 1'b0;
    end else if (pix_valid) begin
      hcnt <= (hcnt == hmax) ? 3'h0 : hcnt + 1'b1;
      cph <= !cph;
      if (!cph) u_hold <= pix_data[7:0];
      else v_hold <= pix_data[7:0];
    end
  end

  // ----------------------------------------------------------------
  // colour path and staging
  // ----------------------------------------------------------------
  vcc_rgb u_rgb (
    .clk(ref_clk),
    .rst_n(arst_n),
    .y(pix_data[15:8]),
    .u(cph ? u_hold : pix_data[7:0]),
    .v(cph ? pix_data[7:0] : v_hold),
    .rgb(rgb_q)
  );

  // raw word and sideband for the kept pixel
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stg_valid <= 1'b0;
      stg_raw <= '0;
      stg_field <= 1'b0;
      stg_first <= 1'b0;
    end else begin
      stg_valid <= take;
      if (take) begin
        stg_raw <= pix_data;
        stg_field <= fld_par; // writer interleaves by field
        stg_first <= pend_first;
      end
    end
  end

  assign stg_word = act_rgb ? rgb_q : stg_raw;

  // video cannot stall: a word refused by a full fifo is dropped and flagged
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ovf <= 1'b0;
    end else if (stg_valid && !fifo_in_ready) begin
      ovf <= 1'b1;
    end else if (apb_wr && paddr == STAT_OFS && pwdata[ST_OVF_BIT]) begin
      ovf <= 1'b0;
    end
  end

  vcc_fifo #(
    .WIDTH(PIX_W + 2),
    .DEPTH(FDEPTH)
  ) u_fifo (
    .clk(ref_clk),
    .rst_n(arst_n),
    .in_valid(stg_valid),
    .in_ready(fifo_in_ready),
    .in_data({stg_field, stg_first, stg_word}),
    .out_valid(st_valid),
    .out_ready(st_ready),
    .out_data({st_field, st_first, st_data})
  );

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  a_odd_field_only: assert property (
    stg_valid && act_fsel == FS_ODD |-> !stg_field)
    else $error("odd-only mode staged an even field pixel");

  a_even_field_only: assert property (
    stg_valid && act_fsel == FS_EVEN |-> stg_field)
    else $error("even-only mode staged an odd field pixel");

  a_enable_gate: assert property (
    !cap_on |=> !stg_valid)
    else $error("pixel staged while capture is off");

  a_start_each_vs: assert property (
    vs_rise && c_fsel == FS_PROG && c_en |=> area_start && act_fsel == FS_PROG)
    else $error("progressive mode missed an area start");

  a_merge_pairs: assert property (
    vs_rise && c_fsel == FS_MERGE && c_en && act_fsel == FS_MERGE && phase
    |=> !area_start ##1 !area_start)
    else $error("merge mode started an area on the second field");

  a_single_field: assert property (
    area_start && act_fsel[1] |-> fld_par == act_fsel[0] && cap_on)
    else $error("single field area started on the wrong field");

  a_vsize_latch: assert property (
    area_start && $past(area_open) |-> storage_vertical_size == $past(line_cnt))
    else $error("vertical size not taken from the closing area");

  a_raw_store: assert property (
    take && !act_rgb ##1 !vs_rise[*1] |-> stg_word == $past(pix_data))
    else $error("unconverted word differs from the captured pixel");

  a_cfg_boundary: assert property (
    $changed(act_fsel) || $changed(act_rgb) || $changed(act_red) |-> $past(vs_rise))
    else $error("active setting changed away from a sync edge");

  a_vert_thin: assert property (
    line_rise && !line_first && vcnt != act_red[4:3] |-> !keep_now)
    else $error("line kept inside the vertical reduction period");

  c_merge_area: cover property (area_start && act_fsel == FS_MERGE);
  c_rgb_pixel: cover property (stg_valid && act_rgb && !red_bad);
  c_fifo_full: cover property (stg_valid && !fifo_in_ready);
  c_odd_skip: cover property (vs_rise && c_fsel == FS_ODD ##1 !cap_on);
endmodule

// ---- test/test_video_capture_control.sv ----
// test_video_capture_control: self-checking bench for vcc_top
// assumes vcc_src drives the video inputs and the bench drains the store side
`timescale 1ns/100ps
module test_video_capture_control;
  import vcc_pkg::*;
  localparam logic [31:0] OK = 32'h180c_1e07; // allowed reduction codes
  logic ref_clk = 0;
  logic arst_n = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic st_ready = 0;
  logic hold = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, st_valid, st_field, st_first, area_start;
  logic [1:0] area_idx;
  logic [1:0] aidx = 2'h0;
  logic [15:0] st_data;
  wire vs, fp, lv, pv;
  wire [15:0] pd;
  logic [17:0] sq[$];
  logic [32:0] rq[$];
  logic [32:0] mq[$];
  int n_fail = 0;
  int n_tests = 0;
  int n_area = 0;
  int cyc = 0;

  vcc_top dut (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .video_vsync_in(vs), .field_parity_in(fp), .line_valid_in(lv),
    .pix_valid(pv), .pix_data(pd), .st_valid(st_valid), .st_ready(st_ready),
    .st_data(st_data), .st_field(st_field), .st_first(st_first),
    .area_start(area_start), .area_idx(area_idx));
  vcc_src src (.clk(ref_clk), .vsync(vs), .parity(fp), .line_v(lv), .pix_v(pv), .pix(pd));

  // 20 MHz clock
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end

  // ------------------------------------------------------------
  // checking
  // ------------------------------------------------------------
  task automatic chk(input logic [32:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("tests=%0d fails=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // read results and store words against the oldest notes
  always @(posedge ref_clk) begin
    if (psel && penable && pready && !pwrite) begin
      chk({pslverr, prdata} & mq.pop_front(), rq.pop_front());
    end
    if (st_valid === 1'b1 && st_ready === 1'b1) begin
      chk({st_first, st_field, st_data}, sq.size() > 0 ? 33'(sq.pop_front()) : 33'bx);
    end
    if (area_start === 1'b1) begin
      n_area++;
      aidx = (aidx == AREA_LAST) ? 2'h0 : aidx + 2'h1;
      chk(33'(area_idx), 33'(aidx));
    end
  end

  // consumer stalls about one cycle in four, or fully while hold
  always @(posedge ref_clk) st_ready <= !hold && ($urandom % 4 != 0);

  // hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      end_sim;
    end
  end

  // ------------------------------------------------------------
  // drivers
  // ------------------------------------------------------------
  // one apb transfer; a read notes its masked expectation
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [32:0] e = 33'h0, m = 33'h0);
    @(posedge ref_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) begin
      rq.push_back(e);
      mq.push_back(m);
    end
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask

  // expected stored word: raw, or rgb565 of a grey pixel
  function automatic logic [15:0] px(logic [15:0] b, int l, p, bit g);
    logic [15:0] v;
    v = b + 16'(l << 8) + 16'(p);
    return g ? {v[15:11], v[15:10], v[15:11]} : v;
  endfunction

  // two frames of 12 lines x 6 pixels, then stop and check size and area pulses
  task automatic cap(input logic [9:0] c, input int vs, hs, na, input bit p0, p1);
    logic [1:0] fs;
    logic [15:0] b;
    bit par;
    int kl;
    fs = c[3:2];
    kl = 0;
    n_area = 0;
    apb(1, CTRL_OFS, 32'(c));
    for (int f = 0; f < 2; f++) begin
      par = f ? p1 : p0;
      b = 16'($urandom);
      if (!fs[1] || par == fs[0]) begin
        kl += 12 / vs;
        for (int l = 0; l < 12; l += vs)
          for (int p = 0; p < 6; p += hs)
            sq.push_back({(fs == FS_PROG || f == 0) && l == 0 && p == 0, par, px(b, l, p, c[1])});
      end
      src.frame(par, 12, 6, b, c[1]);
    end
    apb(1, CTRL_OFS, 32'h0000_0000); // stop before reading status
    src.frame(0, 2, 6, 16'h1234, 1); // neutral chroma left in the hold registers
    repeat (400) if (sq.size() > 0) @(posedge ref_clk);
    apb(0, STAT_OFS, 0, 33'(fs == FS_PROG ? 12 / vs : kl), 33'h1_cfff);
    if (na >= 0) chk(33'(n_area), 33'(na));
    $display("test cfg=%h done, fails=%0d", c, n_fail);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [15:0] b;
    void'($urandom(32'h0000_a6e1));
    repeat (2) @(posedge ref_clk);
    arst_n <= 1;
    apb(0, CTRL_OFS, 0, 33'h0, '1);
    apb(0, STAT_OFS, 0, 33'h0, '1);
    apb(1, CTRL_OFS, 32'hffff_ffff);
    apb(0, CTRL_OFS, 0, 33'(CTRL_MASK), '1);
    apb(0, 12'h00c, 0, 33'h1_0000_0000, '1);
    apb(0, ACT_OFS, 0, 33'h0, '1);
    $display("test registers done");
    for (int c = 0; c < 32; c++) begin
      apb(1, CTRL_OFS, 32'(c << 5));
      apb(0, ACT_OFS, 0, 33'(c ? (c - 1) << 5 : 0), '1);
      src.frame(0, 0, 6, 16'h0000, 0);
      apb(0, ACT_OFS, 0, 33'(c << 5), '1);
      apb(0, STAT_OFS, 0, 33'(!OK[c]) << 14, 33'h4000);
    end
    $display("test reduction codes done");
    cap(10'h001, 1, 1, 2, 0, 0);
    src.slow = 1;
    cap(10'h005, 1, 1, 1, 0, 1);
    src.slow = 0;
    cap(10'h009, 1, 1, 1, 0, 1);
    cap(10'h00d, 1, 1, 1, 1, 0);
    cap(10'h003, 1, 1, 2, 0, 0);
    cap(10'h141, 2, 3, 2, 0, 0);
    cap(10'h241, 3, 3, 2, 0, 0);
    cap(10'h381, 4, 4, 2, 0, 0);
    cap(10'h021, 1, 2, 2, 0, 0);
    // fill the buffer with the consumer stalled, then drain it
    hold <= 1;
    b = 16'($urandom);
    apb(1, CTRL_OFS, 32'h0000_0001);
    for (int p = 0; p < 16; p++) sq.push_back({p == 0, 1'b0, px(b, 0, p, 0)});
    src.frame(0, 1, 20, b, 0);
    apb(1, CTRL_OFS, 32'h0000_0000);
    src.frame(0, 0, 6, 16'h0000, 0);
    apb(0, STAT_OFS, 0, 33'h8000, 33'h8000);
    hold <= 0;
    repeat (100) @(posedge ref_clk);
    apb(1, STAT_OFS, 32'h0000_8000);
    apb(0, STAT_OFS, 0, 33'h0, 33'h8000);
    chk(33'(sq.size()), 33'h0);
    $display("test overflow done");
    end_sim;
  end
endmodule

// ---- test/vcc_src.sv ----
// vcc_src: video source model feeding the capture block
// assumes frame() is called from one bench process, one frame at a time
`timescale 1ns/100ps
module vcc_src (
  // clock
  input wire logic clk,
  // video out
  output logic vsync,
  output logic parity,
  output logic line_v,
  output logic pix_v,
  output logic [15:0] pix
);
  bit slow = 0;

  // quiet lines at time zero
  initial begin
    vsync = 0;
    parity = 0;
    line_v = 0;
    pix_v = 0;
    pix = 16'h0000;
  end

  // no pixel: data flips so a stale word never looks valid
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk);
      pix_v <= 0;
      pix <= ~pix;
    end
  endtask

  // one vertical period; grey puts neutral chroma on every pixel
  task automatic frame(input bit par, input int nl, np, input logic [15:0] base,
      input bit grey);
    logic [15:0] v;
    @(posedge clk);
    vsync <= 1;
    parity <= par; // level held for the whole period
    idle(2);
    vsync <= 0;
    for (int l = 0; l < nl; l++) begin
      idle(3);
      for (int p = 0; p < np; p++) begin
        v = base + 16'(l << 8) + 16'(p);
        @(posedge clk);
        line_v <= 1;
        pix_v <= 1;
        pix <= grey ? {v[15:8], 8'h80} : v;
        if (slow) idle(1); // slow source: gap inside the line
      end
      idle(1);
      line_v <= 0;
    end
    idle(4);
  endtask
endmodule
